// [ee_pkg.sv]
// shared constants and types for the two-wire eeprom read side
// Notes on behaviour
// - controller dummy-writes word address before random read
// - after address ack, repeated start then read address
// - device acks read address, shifts out loaded byte
// - single read ends with no-ack then stop
// - ack on a byte continues a sequential read
// - each ack advances address, next byte follows
// - sequential read wraps past top address seamlessly
// - no-ack plus stop ends read, device releases
// - id page read uses id type code
// - id page offset from low six address bits
// - caller, not controller, keeps id reads inside the page
// - lock is id-type byte write, bit 10 set
// - lock takes effect only with data bit 1
// - lock is never cleared except by reset to LOCK_INIT
// - word address sent high byte first
// - separate id page, writable until locked, readable
// - eight-bit bytes, device acks on ninth clock
// - after a read, address counter holds last address plus one
// - read address wraps last page to first
// - locked id page write data gets no-ack
package ee_pkg;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 16;
  localparam int MEM_DEPTH = 65536;
  localparam int ID_DEPTH = 128;
  localparam int ID_IDX_W = 7;
  localparam int ID_OFS_W = 6;
  localparam int LOCK_ADDR_BIT = 10;
  localparam int LOCK_DATA_BIT = 1;
  localparam logic [3:0] TYPE_MEM = 4'hA;
  localparam logic [3:0] TYPE_ID = 4'hB;
  localparam logic [2:0] CHIP_SEL = 3'h0;
  localparam logic [3:0] LAST_BIT_CNT = 4'h7;
  localparam logic [3:0] ACK_CNT = 4'h8;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [7:0] LEFT_ONE = 8'h01;
  localparam int CLK_NS = 100;
  localparam int SCL_QTR_NS = 2500;
  localparam int QTR_CYC = (SCL_QTR_NS + CLK_NS - 1) / CLK_NS;
  localparam int QTR_W = $clog2(QTR_CYC);
  localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);

  typedef enum logic [1:0] {OP_READ_RANDOM, OP_READ_CURRENT, OP_WRITE} op_e;

  // advance within a 128-byte page, upper bits kept
  function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
    page_inc = {a[ADDR_W-1:ID_IDX_W], a[ID_IDX_W-1:0] + 7'h01};
  endfunction
endpackage

// [ee_link_if.sv]
// two-wire link between controller and eeprom, open-drain data
`timescale 1ns/1ns
interface ee_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // wired-and: low whenever an enabled driver pulls low
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface

// [sync2.sv]
// two-flop level synchroniser
`timescale 1ns/1ns
module sync2 (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_r;
  logic q_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= 1'b1;
      q_r    <= 1'b1;
    end else begin
      meta_r <= d_i;
      q_r    <= meta_r;
    end
  end

  assign q_o = q_r;
endmodule

// [eeprom_dev.sv]
// eeprom end of the link: read, id page and lock logic on scl
`timescale 1ns/1ns
module eeprom_dev #(
  parameter logic LOCK_INIT = 1'b0
) (
  ee_link_if.dev    link,
  input  wire logic rst_i,
  output logic      id_locked_o
);
  typedef enum logic [2:0] {S_IDLE, S_DEV, S_AHI, S_ALO, S_WDATA, S_RDATA} dev_state_e;

  logic start_tgl_r;
  logic start_tgl_nxt;
  logic stop_tgl_r;
  logic stop_tgl_nxt;

  dev_state_e               state_r;
  dev_state_e               state_nxt;
  dev_state_e               go_r;
  dev_state_e               go_nxt;
  logic [3:0]               cnt_r;
  logic [3:0]               cnt_nxt;
  logic [ee_pkg::BYTE_W-1:0] shift_r;
  logic [ee_pkg::BYTE_W-1:0] shift_nxt;
  logic [ee_pkg::BYTE_W-1:0] txd_r;
  logic [ee_pkg::BYTE_W-1:0] txd_nxt;
  logic [ee_pkg::ADDR_W-1:0] addr_r;
  logic [ee_pkg::ADDR_W-1:0] addr_nxt;
  logic                     id_sel_r;
  logic                     id_sel_nxt;
  logic                     ack_r;
  logic                     ack_nxt;
  logic                     lock_r;
  logic                     lock_nxt;
  logic                     start_seen_r;
  logic                     start_seen_nxt;
  logic                     stop_seen_r;
  logic                     stop_seen_nxt;
  logic                     mem_we;
  logic                     id_we;
  logic [ee_pkg::BYTE_W-1:0] byte_in;

  logic                     sda_oe_r;
  logic                     sda_oe_nxt;
  logic                     sda_o_r;

  logic [ee_pkg::BYTE_W-1:0] mem [ee_pkg::MEM_DEPTH];
  logic [ee_pkg::BYTE_W-1:0] idp [ee_pkg::ID_DEPTH];

  // byte at an address, from the id page or the main array
  function automatic logic [ee_pkg::BYTE_W-1:0] fetch(input logic [ee_pkg::ADDR_W-1:0] a,
                                                     input logic id);
    fetch = id ? idp[a[ee_pkg::ID_IDX_W-1:0]] : mem[a];
  endfunction

  // next counter value: whole array wraps, id page wraps in page
  function automatic logic [ee_pkg::ADDR_W-1:0] next_addr(input logic [ee_pkg::ADDR_W-1:0] a,
                                                         input logic id);
    next_addr = id ? ee_pkg::page_inc(a) : a + 16'h0001;
  endfunction

  // start and stop seen as sda edges while scl high
  always_comb begin
    start_tgl_nxt = link.scl ? !start_tgl_r : start_tgl_r;
    stop_tgl_nxt  = link.scl ? !stop_tgl_r : stop_tgl_r;
  end

  always_ff @(negedge link.sda or posedge rst_i) begin
    if (rst_i) begin
      start_tgl_r <= 1'b0;
    end else begin
      start_tgl_r <= start_tgl_nxt;
    end
  end

  always_ff @(posedge link.sda or posedge rst_i) begin
    if (rst_i) begin
      stop_tgl_r <= 1'b0;
    end else begin
      stop_tgl_r <= stop_tgl_nxt;
    end
  end

  // toggles are read only at scl edges, which trail the sda
  // edge by at least a quarter of an scl period, so they are settled

  always_comb begin
    state_nxt      = state_r;
    go_nxt         = go_r;
    cnt_nxt        = cnt_r;
    shift_nxt      = shift_r;
    txd_nxt        = txd_r;
    addr_nxt       = addr_r;
    id_sel_nxt     = id_sel_r;
    ack_nxt        = ack_r;
    lock_nxt       = lock_r;
    start_seen_nxt = start_seen_r;
    stop_seen_nxt  = stop_seen_r;
    mem_we         = 1'b0;
    id_we          = 1'b0;
    byte_in        = {shift_r[ee_pkg::BYTE_W-2:0], link.sda};

    if (start_tgl_r != start_seen_r) begin
      // this edge carries the top bit of the address byte
      start_seen_nxt = start_tgl_r;
      stop_seen_nxt  = stop_tgl_r;
      state_nxt      = S_DEV;
      cnt_nxt        = ee_pkg::CNT_ONE;
      shift_nxt      = {{(ee_pkg::BYTE_W-1){1'b0}}, link.sda};
      ack_nxt        = 1'b0;
    end else if (stop_tgl_r != stop_seen_r) begin
      stop_seen_nxt = stop_tgl_r;
      state_nxt     = S_IDLE;
      cnt_nxt       = 4'h0;
      ack_nxt       = 1'b0;
    end else begin
      case (state_r)
        S_IDLE: begin
          cnt_nxt = 4'h0;
        end
        S_RDATA: begin
          if (cnt_r != ee_pkg::ACK_CNT) begin
            cnt_nxt = cnt_r + ee_pkg::CNT_ONE;
          end else begin
            cnt_nxt  = 4'h0;
            addr_nxt = next_addr(addr_r, id_sel_r);
            if (!link.sda) begin
              txd_nxt = fetch(addr_nxt, id_sel_r);
            end else begin
              state_nxt = S_IDLE;
            end
          end
        end
        default: begin
          if (cnt_r != ee_pkg::ACK_CNT) begin
            shift_nxt = byte_in;
            cnt_nxt   = cnt_r + ee_pkg::CNT_ONE;
            if (cnt_r == ee_pkg::LAST_BIT_CNT) begin
              ack_nxt = 1'b1;
              case (state_r)
                S_DEV: begin
                  if (byte_in[7:4] == ee_pkg::TYPE_MEM || byte_in[7:4] == ee_pkg::TYPE_ID) begin
                    id_sel_nxt = (byte_in[7:4] == ee_pkg::TYPE_ID);
                    go_nxt     = byte_in[0] ? S_RDATA : S_AHI;
                  end else begin
                    ack_nxt = 1'b0;
                    go_nxt  = S_IDLE;
                  end
                end
                S_AHI: begin
                  addr_nxt[ee_pkg::ADDR_W-1:ee_pkg::BYTE_W] = byte_in;
                  go_nxt = S_ALO;
                end
                S_ALO: begin
                  addr_nxt[ee_pkg::BYTE_W-1:0] = byte_in;
                  if (id_sel_r) begin
                    addr_nxt[ee_pkg::ID_OFS_W] = 1'b0;
                  end
                  go_nxt = S_WDATA;
                end
                default: begin
                  go_nxt = S_WDATA;
                  if (id_sel_r && addr_r[ee_pkg::LOCK_ADDR_BIT]) begin
                    if (byte_in[ee_pkg::LOCK_DATA_BIT]) begin
                      lock_nxt = 1'b1;
                    end
                  end else if (id_sel_r) begin
                    ack_nxt = !lock_r;
                    if (!lock_r) begin
                      id_we    = 1'b1;
                      addr_nxt = ee_pkg::page_inc(addr_r);
                    end
                  end else begin
                    mem_we   = 1'b1;
                    addr_nxt = ee_pkg::page_inc(addr_r);
                  end
                end
              endcase
            end
          end else begin
            cnt_nxt   = 4'h0;
            ack_nxt   = 1'b0;
            state_nxt = go_r;
            if (go_r == S_RDATA) begin
              txd_nxt = fetch(addr_r, id_sel_r);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge link.scl or posedge rst_i) begin
    if (rst_i) begin
      state_r      <= S_IDLE;
      go_r         <= S_IDLE;
      cnt_r        <= 4'h0;
      shift_r      <= 8'h00;
      txd_r        <= 8'h00;
      addr_r       <= 16'h0000;
      id_sel_r     <= 1'b0;
      ack_r        <= 1'b0;
      lock_r       <= LOCK_INIT;
      start_seen_r <= 1'b0;
      stop_seen_r  <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      go_r         <= go_nxt;
      cnt_r        <= cnt_nxt;
      shift_r      <= shift_nxt;
      txd_r        <= txd_nxt;
      addr_r       <= addr_nxt;
      id_sel_r     <= id_sel_nxt;
      ack_r        <= ack_nxt;
      lock_r       <= lock_nxt;
      start_seen_r <= start_seen_nxt;
      stop_seen_r  <= stop_seen_nxt;
    end
  end

  always_ff @(posedge link.scl) begin
    if (mem_we) begin
      mem[addr_r] <= byte_in;
    end
    if (id_we) begin
      idp[addr_r[ee_pkg::ID_IDX_W-1:0]] <= byte_in;
    end
  end

  // data driven while scl low, msb first
  always_comb begin
    sda_oe_nxt = 1'b0;
    if (start_tgl_r != start_seen_r || stop_tgl_r != stop_seen_r) begin
      sda_oe_nxt = 1'b0;
    end else if (state_r == S_RDATA && cnt_r != ee_pkg::ACK_CNT) begin
      sda_oe_nxt = !txd_r[3'(ee_pkg::LAST_BIT_CNT - cnt_r)];
    end else if (state_r != S_IDLE && state_r != S_RDATA && cnt_r == ee_pkg::ACK_CNT) begin
      sda_oe_nxt = ack_r;
    end
  end

  always_ff @(negedge link.scl or posedge rst_i) begin
    if (rst_i) begin
      sda_oe_r <= 1'b0;
      sda_o_r  <= 1'b0;
    end else begin
      sda_oe_r <= sda_oe_nxt;
      sda_o_r  <= 1'b0;
    end
  end

  assign link.dev_sda_oe = sda_oe_r;
  assign link.dev_sda_o  = sda_o_r;
  assign id_locked_o     = lock_r;
endmodule

// [eeprom_host.sv]
// controller end of the link: command sequencer, scl divider
`timescale 1ns/1ns
module eeprom_host (
  ee_link_if.host     link,
  input  wire logic   core_clk_i,
  input  wire logic   rst_i,
  input  wire logic   cmd_valid_i,
  input  ee_pkg::op_e cmd_op_i,
  input  wire logic   cmd_id_page_i,
  input  wire logic [15:0] cmd_addr_i,
  input  wire logic [7:0]  cmd_wdata_i,
  input  wire logic [7:0]  cmd_count_i,
  output logic        cmd_ready_o,
  output logic [7:0]  rd_data_o,
  output logic        rd_valid_o,
  output logic        done_o,
  output logic        nack_o
);
  typedef enum logic [2:0] {H_IDLE, H_START, H_TX, H_RX, H_STOP} host_state_e;

  host_state_e             st_r, st_nxt;
  ee_pkg::op_e             op_r, op_nxt;
  logic [ee_pkg::QTR_W-1:0] q_r, q_nxt;
  logic [1:0]              ph_r, ph_nxt;
  logic [3:0]              bit_r, bit_nxt;
  logic [1:0]              step_r, step_nxt;
  logic [7:0]              sh_r, sh_nxt;
  logic [7:0]              left_r, left_nxt;
  logic [15:0]             addr_r, addr_nxt;
  logic [7:0]              wdata_r, wdata_nxt;
  logic                    id_r, id_nxt, rsd_r, rsd_nxt, rd_r, rd_nxt, nak_r, nak_nxt;
  logic                    scl_r, scl_nxt, oe_r, oe_nxt, ready_r, ready_nxt;
  logic [7:0]              rdat_r, rdat_nxt;
  logic                    rval_r, rval_nxt, done_r, done_nxt, nack_r, nack_nxt;
  logic                    sda_s, qend, send;

  sync2 u_sda_sync (
    .clk_i (core_clk_i),
    .rst_i (rst_i),
    .d_i   (link.sda),
    .q_o   (sda_s)
  );

  always_comb begin
    {st_nxt, op_nxt, ph_nxt, bit_nxt, step_nxt, sh_nxt} = {st_r, op_r, ph_r, bit_r, step_r, sh_r};
    {left_nxt, addr_nxt, wdata_nxt, id_nxt, rsd_nxt, rd_nxt} = {left_r, addr_r, wdata_r, id_r, rsd_r, rd_r};
    {nak_nxt, ready_nxt, rdat_nxt, nack_nxt} = {nak_r, ready_r, rdat_r, nack_r};
    rval_nxt = 1'b0;
    done_nxt = 1'b0;
    qend     = (q_r == ee_pkg::QTR_LAST);
    send     = qend && ph_r == 2'h3;
    q_nxt    = (st_r == H_IDLE || qend) ? '0 : q_r + 1'b1;
    if (st_r != H_IDLE && qend) begin
      ph_nxt = ph_r + 2'h1;
    end
    case (st_r)
      H_IDLE: begin
        if (cmd_valid_i) begin
          {op_nxt, id_nxt, addr_nxt, wdata_nxt} = {cmd_op_i, cmd_id_page_i, cmd_addr_i, cmd_wdata_i};
          // caller keeps id offset plus count within the page
          left_nxt  = (cmd_count_i == 8'h00) ? ee_pkg::LEFT_ONE : cmd_count_i;
          rsd_nxt   = 1'b0;
          nack_nxt  = 1'b0;
          ready_nxt = 1'b0;
          ph_nxt    = 2'h0;
          st_nxt    = H_START;
        end
      end
      H_START: begin
        if (send) begin
          // repeated start switches to read
          rd_nxt   = (op_r == ee_pkg::OP_READ_CURRENT) || rsd_r;
          sh_nxt   = {id_r ? ee_pkg::TYPE_ID : ee_pkg::TYPE_MEM, ee_pkg::CHIP_SEL, rd_nxt};
          bit_nxt  = 4'h0;
          step_nxt = 2'h0;
          st_nxt   = H_TX;
        end
      end
      H_TX: begin
        if (qend && ph_r == 2'h2 && bit_r == ee_pkg::ACK_CNT) begin
          nak_nxt = sda_s;
        end
        if (send && bit_r != ee_pkg::ACK_CNT) begin
          sh_nxt  = {sh_r[6:0], 1'b0};
          bit_nxt = bit_r + 4'h1;
        end else if (send) begin
          bit_nxt  = 4'h0;
          step_nxt = step_r + 2'h1;
          if (nak_r) begin
            nack_nxt = 1'b1;
            st_nxt   = H_STOP;
          end else if (rd_r) begin
            st_nxt = H_RX;
          end else begin
            // dummy write: high then low address byte
            case (step_r)
              2'h0: sh_nxt = addr_r[15:8];
              2'h1: sh_nxt = addr_r[7:0];
              2'h2: begin
                if (op_r == ee_pkg::OP_WRITE) begin
                  sh_nxt = wdata_r;
                end else begin
                  rsd_nxt = 1'b1;
                  st_nxt  = H_START;
                end
              end
              default: st_nxt = H_STOP;
            endcase
          end
        end
      end
      H_RX: begin
        if (qend && ph_r == 2'h2 && bit_r != ee_pkg::ACK_CNT) begin
          sh_nxt = {sh_r[6:0], sda_s};
        end
        if (send && bit_r != ee_pkg::ACK_CNT) begin
          bit_nxt = bit_r + 4'h1;
        end else if (send) begin
          bit_nxt  = 4'h0;
          rval_nxt = 1'b1;
          rdat_nxt = sh_r;
          left_nxt = left_r - 8'h01;
          // last byte: no-ack then stop
          st_nxt   = (left_r == ee_pkg::LEFT_ONE) ? H_STOP : H_RX;
        end
      end
      H_STOP: begin
        if (send) begin
          st_nxt    = H_IDLE;
          done_nxt  = 1'b1;
          ready_nxt = 1'b1;
        end
      end
      default: st_nxt = H_IDLE;
    endcase
    scl_nxt = st_r == H_IDLE || ph_r == 2'h1 || ph_r == 2'h2 || (st_r == H_STOP && ph_r == 2'h3);
    case (st_r)
      H_START: oe_nxt = ph_r[1];
      H_STOP:  oe_nxt = !ph_r[1];
      H_TX:    oe_nxt = (bit_r != ee_pkg::ACK_CNT) && !sh_r[7];
      H_RX:    oe_nxt = (bit_r == ee_pkg::ACK_CNT) && (left_r != ee_pkg::LEFT_ONE);
      default: oe_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {st_r, op_r, q_r, ph_r, bit_r, step_r, sh_r} <= {H_IDLE, ee_pkg::OP_READ_RANDOM, {ee_pkg::QTR_W{1'b0}},
                                                       2'h0, 4'h0, 2'h0, 8'h00};
      {left_r, addr_r, wdata_r, id_r, rsd_r, rd_r, nak_r} <= {8'h00, 16'h0000, 8'h00, 4'h0};
      {scl_r, oe_r, ready_r, rdat_r, rval_r, done_r, nack_r} <= {3'h5, 8'h00, 3'h0};
    end else begin
      {st_r, op_r, q_r, ph_r, bit_r, step_r, sh_r} <= {st_nxt, op_nxt, q_nxt, ph_nxt, bit_nxt, step_nxt, sh_nxt};
      {left_r, addr_r, wdata_r, id_r, rsd_r, rd_r, nak_r} <= {left_nxt, addr_nxt, wdata_nxt, id_nxt, rsd_nxt, rd_nxt, nak_nxt};
      {scl_r, oe_r, ready_r, rdat_r, rval_r, done_r, nack_r} <= {scl_nxt, oe_nxt, ready_nxt, rdat_nxt, rval_nxt, done_nxt, nack_nxt};
    end
  end

  assign link.scl         = scl_r;
  assign link.host_sda_oe = oe_r;
  assign link.host_sda_o  = 1'b0;
  assign cmd_ready_o      = ready_r;
  assign rd_data_o        = rdat_r;
  assign rd_valid_o       = rval_r;
  assign done_o           = done_r;
  assign nack_o           = nack_r;
endmodule

// [ee_link_chk.sv]
// concurrent checks on the two-wire link between controller and eeprom
`timescale 1ns/1ns
module ee_link_chk (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic scl,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  logic       scl_d_r;
  logic       sda_d_r;
  logic [3:0] bit_r;
  logic [3:0] bit_nxt;
  logic [1:0] byte_r;
  logic [1:0] byte_nxt;
  logic       rw_r;
  logic       rw_nxt;
  logic       acked_r;
  logic       acked_nxt;
  logic       rise;
  logic       start;

  // bit and byte position since the last start, direction bit
  always_comb begin
    rise     = scl && !scl_d_r;
    start    = scl && scl_d_r && sda_d_r && !sda;
    bit_nxt  = bit_r;
    byte_nxt = byte_r;
    rw_nxt   = rw_r;
    acked_nxt = acked_r;
    if (start) begin
      bit_nxt  = 4'h0;
      byte_nxt = 2'h0;
      acked_nxt = 1'b1;
    end else if (rise) begin
      // a no-ack leaves the line to the controller for the stop
      if (bit_r == 4'h8) begin
        acked_nxt = !sda;
      end
      bit_nxt = (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
      if (bit_r == 4'h8 && byte_r != 2'h3) begin
        byte_nxt = byte_r + 2'h1;
      end
      if (bit_r == 4'h7 && byte_r == 2'h0) begin
        rw_nxt = sda;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      bit_r   <= 4'h0;
      byte_r  <= 2'h0;
      rw_r    <= 1'b0;
      acked_r <= 1'b1;
    end else begin
      scl_d_r <= scl;
      sda_d_r <= sda;
      bit_r   <= bit_nxt;
      byte_r  <= byte_nxt;
      rw_r    <= rw_nxt;
      acked_r <= acked_nxt;
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  a_start_by_host:
    assert property ($fell(sda) && scl && $past(scl) |-> host_sda_oe && !dev_sda_oe)
      else $error("start not made by controller alone");
  a_dev_on_fall:
    assert property ($changed(dev_sda_oe) |-> $fell(scl))
      else $error("device data moved off a clock fall");
  a_addr_quiet:
    assert property ($rose(scl) && byte_r == 2'h0 && bit_r != 4'h8 |-> !dev_sda_oe)
      else $error("device drove during address bits");
  a_addr_ack:
    assert property ($rose(scl) && byte_r == 2'h0 && bit_r == 4'h8 |-> dev_sda_oe && !sda)
      else $error("device address not acknowledged");
  a_word_ack:
    assert property ($rose(scl) && !rw_r && byte_r inside {2'h1, 2'h2} && bit_r == 4'h8 |-> dev_sda_oe)
      else $error("word address byte not acknowledged");
  a_rd_host_off:
    assert property ($rose(scl) && rw_r && acked_r && byte_r != 2'h0 && bit_r != 4'h8 |-> !host_sda_oe)
      else $error("controller drove during read data");
  a_rd_ack_free:
    assert property ($rose(scl) && rw_r && byte_r != 2'h0 && bit_r == 4'h8 |-> !dev_sda_oe)
      else $error("device held line in read ack slot");
  a_nack_quit:
    assert property ($rose(scl) && rw_r && byte_r != 2'h0 && bit_r == 4'h8 && sda |-> ##60 !dev_sda_oe)
      else $error("device kept sending after no-ack");
  a_stop_release:
    assert property (scl && $past(scl) && $rose(sda) |-> ##1 (!dev_sda_oe) [*8])
      else $error("device drove after stop");

  c_seq_ack: cover property ($rose(scl) && rw_r && byte_r == 2'h3 && bit_r == 4'h8 && !sda);
  c_restart: cover property (scl && $past(scl) && $fell(sda) && byte_r == 2'h3);
  c_stop: cover property (scl && $past(scl) && $rose(sda));
endmodule

// [serial_eeprom_read_idpage_tb.sv]
// self-checking bench: controller and eeprom joined by the link
`timescale 1ns/1ns
module serial_eeprom_read_idpage_tb;
  logic              core_clk_i;
  logic              rst_i;
  logic              cmd_valid_i;
  ee_pkg::op_e       cmd_op_i;
  logic              cmd_id_page_i;
  logic [15:0]       cmd_addr_i;
  logic [7:0]        cmd_wdata_i;
  logic [7:0]        cmd_count_i;
  logic              cmd_ready_o;
  logic [7:0]        rd_data_o;
  logic              rd_valid_o;
  logic              done_o;
  logic              nack_o;
  logic              id_locked_o;
  int                bad_count;
  int                n_tests;
  int                seed;
  logic              lock_m;
  logic [15:0]       cur_m;
  logic [15:0]       a;
  logic [7:0]        got[$];
  logic [7:0]        mem_m[logic [15:0]];
  logic [7:0]        idp_m[0:127];

  ee_link_if ee_link_if_inst ();
  eeprom_host eeprom_host_inst (.link(ee_link_if_inst), .core_clk_i, .rst_i, .cmd_valid_i, .cmd_op_i,
    .cmd_id_page_i, .cmd_addr_i, .cmd_wdata_i, .cmd_count_i, .cmd_ready_o, .rd_data_o, .rd_valid_o,
    .done_o, .nack_o);
  eeprom_dev #(.LOCK_INIT(1'b0)) eeprom_dev_inst (.link(ee_link_if_inst), .rst_i, .id_locked_o);
  ee_link_chk ee_link_chk_inst (.core_clk_i, .rst_i, .scl(ee_link_if_inst.scl),
    .host_sda_oe(ee_link_if_inst.host_sda_oe), .dev_sda_oe(ee_link_if_inst.dev_sda_oe),
    .sda(ee_link_if_inst.sda));

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // wrap: 16 bits in the array, 7 bits in the id page
  function automatic logic [7:0] exp_byte(input logic idp, input logic [15:0] base, input int k);
    logic [15:0] m;
    logic [6:0]  i;
    m = base + 16'(k);
    i = {1'b0, base[5:0]} + 7'(k);
    return idp ? idp_m[i] : mem_m[m];
  endfunction

  task automatic run(input ee_pkg::op_e op, input logic idp, input logic [15:0] addr,
                     input logic [7:0] wd, input logic [7:0] cnt);
    int i;
    got.delete();
    @(negedge core_clk_i);
    cmd_op_i      = op;
    cmd_id_page_i = idp;
    cmd_addr_i    = addr;
    cmd_wdata_i   = wd;
    cmd_count_i   = cnt;
    cmd_valid_i   = 1'b1;
    for (i = 0; i < 50 && cmd_ready_o !== 1'b1; i++) begin
      @(negedge core_clk_i);
    end
    check("ready", {7'h00, cmd_ready_o}, 8'h01);
    @(negedge core_clk_i);
    cmd_valid_i = 1'b0;
    for (i = 0; i < 20000 && done_o !== 1'b1; i++) begin
      @(negedge core_clk_i);
      if (rd_valid_o === 1'b1) begin
        got.push_back(rd_data_o);
      end
    end
    if (done_o !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED done expected 1 seen %b", done_o);
      finish_test();
    end
  endtask

  task automatic wr(input logic idp, input logic [15:0] addr, input logic [7:0] data);
    logic refuse;
    refuse = idp && lock_m && !addr[10];
    run(ee_pkg::OP_WRITE, idp, addr, data, 8'h01);
    check("write nack", {7'h00, nack_o}, {7'h00, refuse});
    if (!idp) begin
      mem_m[addr] = data;
    end else if (!refuse && !addr[10]) begin
      idp_m[{1'b0, addr[5:0]}] = data;
    end
    if (idp && addr[10] && data[1]) begin
      lock_m = 1'b1;
    end
    check("lock flag", {7'h00, id_locked_o}, {7'h00, lock_m});
    $display("test write %h done", addr);
  endtask

  task automatic rd(input ee_pkg::op_e op, input logic idp, input logic [15:0] addr, input logic [7:0] cnt);
    logic [15:0] base;
    base = (op == ee_pkg::OP_READ_CURRENT) ? cur_m : addr;
    run(op, idp, addr, 8'h00, cnt);
    check("read count", 8'(got.size()), cnt);
    for (int k = 0; k < got.size(); k++) begin
      check("read data", got[k], exp_byte(idp, base, k));
    end
    if (!idp) begin
      cur_m = base + 16'(cnt);
    end
    $display("test read %h done", addr);
  endtask

  initial begin
    seed          = 93;
    bad_count     = 0;
    n_tests       = 0;
    lock_m        = 1'b0;
    cur_m         = 16'h0000;
    rst_i         = 1'b1;
    cmd_valid_i   = 1'b0;
    cmd_op_i      = ee_pkg::OP_READ_RANDOM;
    cmd_id_page_i = 1'b0;
    cmd_addr_i    = 16'h0000;
    cmd_wdata_i   = 8'h00;
    cmd_count_i   = 8'h00;
    repeat (4) @(negedge core_clk_i);
    rst_i = 1'b0;
    check("lock after reset", {7'h00, id_locked_o}, 8'h00);
    for (int k = 0; k < 3; k++) begin
      a = 16'hFFFE + 16'(k);
      wr(1'b0, a, 8'($random(seed)));
    end
    rd(ee_pkg::OP_READ_RANDOM, 1'b0, 16'hFFFE, 8'h03);
    rd(ee_pkg::OP_READ_RANDOM, 1'b0, 16'hFFFE, 8'h01);
    rd(ee_pkg::OP_READ_CURRENT, 1'b0, 16'h1234, 8'h02);
    for (int k = 0; k < 2; k++) begin
      a = 16'($random(seed));
      wr(1'b0, a, 8'($random(seed)));
      rd(ee_pkg::OP_READ_RANDOM, 1'b0, a, 8'h01);
    end
    for (int k = 0; k < 2; k++) begin
      a = 16'($random(seed));
      wr(1'b1, {a[15:11], 1'b0, a[9:6], 6'h3E + 6'(k)}, 8'($random(seed)));
    end
    a = 16'($random(seed));
    rd(ee_pkg::OP_READ_RANDOM, 1'b1, {a[15:6], 6'h3E}, 8'h02);
    a = 16'($random(seed));
    wr(1'b1, {a[15:11], 1'b1, a[9:6], 6'h00}, 8'($random(seed)) & 8'hFD);
    wr(1'b1, {a[15:11], 1'b1, a[9:6], 6'h00}, 8'($random(seed)) | 8'h02);
    wr(1'b1, {a[15:11], 1'b0, a[9:6], 6'h3E}, 8'($random(seed)));
    rd(ee_pkg::OP_READ_RANDOM, 1'b1, {a[15:6], 6'h3E}, 8'h02);
    finish_test();
  end
endmodule
